// File: hw/ifdec_decoder.sv
`timescale 1ns/1ps

module ifdec_decoder import ifdec_pkg::*; (
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   // Fetch side
   input wire logic instr_valid_in,
   input wire ifdec_word_t instr_in,
   input wire logic [IFD_AW-1:0] pc_in,
   // Datapath side
   output ifdec_out_t dec_out
);

   ifdec_out_t dec_r;
   ifdec_out_t dec_nxt;
   ifdec_word_t w;
   logic [IFD_AW-1:0] d4z;
   logic [IFD_AW-1:0] d8z;
   logic [IFD_AW-1:0] d8s;
   logic [IFD_AW-1:0] d12s;
   logic [IFD_AW-1:0] pcb;

   function automatic logic [IFD_AW-1:0] scale_f(input logic [IFD_AW-1:0] v,
                                                 input logic [1:0] sh);
      scale_f = v << sh;
   endfunction : scale_f

   assign w = instr_in;
   assign d4z = {28'h0000000, w.fd};
   assign d8z = {24'h000000, w.fm, w.fd};
   assign d8s = {{24{w.fm[3]}}, w.fm, w.fd};
   assign d12s = {{20{w.fn[3]}}, w.fn, w.fm, w.fd};

   ////////////////////////////////////////////////////////////////////////
   // Field extraction; the opcode nibbles pick the format
   always_comb begin
      dec_nxt = IFD_DEC_RST;
      pcb = pc_in;
      case (w.op)
         4'h0: begin
            case (w.fd)
               4'h2, 4'ha: begin
                  dec_nxt.fmt = IFD_FMT_N;
                  dec_nxt.src_kind = IFD_OPK_CTRL;
                  dec_nxt.dst_kind = IFD_OPK_REG;
                  dec_nxt.dst_reg = w.fn;
               end
               4'h9: begin
                  // Only the t-flag move carries a register; the rest are bare
                  if (w.fm == 4'h2) begin
                     dec_nxt.fmt = IFD_FMT_N;
                     dec_nxt.dst_kind = IFD_OPK_REG;
                     dec_nxt.dst_reg = w.fn;
                  end else begin
                     dec_nxt.fmt = IFD_FMT_ZERO;
                  end
               end
               4'h3: begin
                  dec_nxt.fmt = IFD_FMT_M;
                  dec_nxt.src_kind = IFD_OPK_REG;
                  dec_nxt.src_reg = w.fn;
               end
               4'h4, 4'h5, 4'h6, 4'h7, 4'hc, 4'hd, 4'he: begin
                  dec_nxt.fmt = IFD_FMT_NM;
                  dec_nxt.src_reg = w.fm;
                  dec_nxt.dst_reg = w.fn;
                  dec_nxt.size = ifdec_size_t'(w.fd[1:0]);
                  dec_nxt.src_kind = w.fd[3] ? IFD_OPK_IDXR0 : IFD_OPK_REG;
                  dec_nxt.dst_kind = (w.fd[3] || w.fd == 4'h7) ? IFD_OPK_REG
                                                                : IFD_OPK_IDXR0;
               end
               4'hf: begin
                  dec_nxt.fmt = IFD_FMT_NM;
                  dec_nxt.src_kind = IFD_OPK_POSTINC;
                  dec_nxt.dst_kind = IFD_OPK_MAC;
                  dec_nxt.src_reg = w.fm;
                  dec_nxt.dst_reg = w.fn;
               end
               default: dec_nxt.fmt = IFD_FMT_ZERO;
            endcase
         end
         4'h1, 4'h5: begin
            dec_nxt.fmt = IFD_FMT_NMD;
            dec_nxt.size = IFD_SZ_LONG;
            dec_nxt.src_reg = w.fm;
            dec_nxt.dst_reg = w.fn;
            dec_nxt.disp = scale_f(d4z, IFD_SZ_LONG);
            dec_nxt.src_kind = w.op[2] ? IFD_OPK_DISP : IFD_OPK_REG;
            dec_nxt.dst_kind = w.op[2] ? IFD_OPK_REG : IFD_OPK_DISP;
         end
         4'h2, 4'h3, 4'h6: begin
            dec_nxt.fmt = IFD_FMT_NM;
            dec_nxt.src_reg = w.fm;
            dec_nxt.dst_reg = w.fn;
            dec_nxt.size = ifdec_size_t'(w.fd[1:0]);
            dec_nxt.src_kind = IFD_OPK_REG;
            dec_nxt.dst_kind = IFD_OPK_REG;
            if (w.op == 4'h2 && w.fd[3:2] == 2'h0) begin
               dec_nxt.dst_kind = IFD_OPK_IND;
            end else if (w.op == 4'h2 && w.fd[3:2] == 2'h1) begin
               dec_nxt.dst_kind = IFD_OPK_PREDEC;
            end else if (w.op == 4'h6 && w.fd[3:2] == 2'h0) begin
               dec_nxt.src_kind = IFD_OPK_IND;
            end else if (w.op == 4'h6 && w.fd[3:2] == 2'h1) begin
               dec_nxt.src_kind = IFD_OPK_POSTINC;
            end
         end
         4'h4: begin
            case (w.fd)
               4'h2, 4'h3: begin
                  dec_nxt.fmt = IFD_FMT_N;
                  dec_nxt.src_kind = IFD_OPK_CTRL;
                  dec_nxt.dst_kind = IFD_OPK_PREDEC;
                  dec_nxt.dst_reg = w.fn;
                  dec_nxt.size = IFD_SZ_LONG;
               end
               4'h6, 4'h7, 4'ha, 4'he: begin
                  dec_nxt.fmt = IFD_FMT_M;
                  dec_nxt.src_reg = w.fn;
                  dec_nxt.src_kind = w.fd[3] ? IFD_OPK_REG : IFD_OPK_POSTINC;
                  dec_nxt.dst_kind = IFD_OPK_CTRL;
                  dec_nxt.size = IFD_SZ_LONG;
               end
               4'hb: begin
                  dec_nxt.fmt = IFD_FMT_M;
                  dec_nxt.src_reg = w.fn;
                  dec_nxt.src_kind = IFD_OPK_REG;
               end
               4'hf: begin
                  dec_nxt.fmt = IFD_FMT_NM;
                  dec_nxt.src_kind = IFD_OPK_POSTINC;
                  dec_nxt.dst_kind = IFD_OPK_MAC;
                  dec_nxt.src_reg = w.fm;
                  dec_nxt.dst_reg = w.fn;
                  dec_nxt.size = IFD_SZ_WORD;
               end
               default: begin
                  dec_nxt.fmt = IFD_FMT_N;
                  dec_nxt.dst_kind = IFD_OPK_REG;
                  dec_nxt.dst_reg = w.fn;
               end
            endcase
         end
         4'h7, 4'he: begin
            dec_nxt.fmt = IFD_FMT_NI;
            dec_nxt.src_kind = IFD_OPK_IMM;
            dec_nxt.dst_kind = IFD_OPK_REG;
            dec_nxt.dst_reg = w.fn;
            dec_nxt.imm = d8s;
         end
         4'h8: begin
            dec_nxt.size = ifdec_size_t'(w.fn[1:0]);
            case (w.fn)
               4'h0, 4'h1, 4'h4, 4'h5: begin
                  // Base register sits in bits 7..4 for both short forms
                  dec_nxt.fmt = w.fn[2] ? IFD_FMT_MD : IFD_FMT_ND4;
                  dec_nxt.src_kind = w.fn[2] ? IFD_OPK_DISP : IFD_OPK_R0;
                  dec_nxt.dst_kind = w.fn[2] ? IFD_OPK_R0 : IFD_OPK_DISP;
                  dec_nxt.src_reg = w.fn[2] ? w.fm : 4'h0;
                  dec_nxt.dst_reg = w.fn[2] ? 4'h0 : w.fm;
                  dec_nxt.disp = scale_f(d4z, w.fn[1:0]);
               end
               4'h8: begin
                  dec_nxt.fmt = IFD_FMT_I;
                  dec_nxt.src_kind = IFD_OPK_IMM;
                  dec_nxt.dst_kind = IFD_OPK_R0;
                  dec_nxt.imm = d8s;
               end
               4'h9, 4'hb, 4'hd, 4'hf: begin
                  dec_nxt.fmt = IFD_FMT_D;
                  dec_nxt.src_kind = IFD_OPK_PCREL;
                  dec_nxt.disp = scale_f(d8s, IFD_BR_SHIFT);
               end
               default: dec_nxt.fmt = IFD_FMT_NOP;
            endcase
         end
         4'h9, 4'hd: begin
            dec_nxt.fmt = IFD_FMT_ND8;
            dec_nxt.size = w.op[2] ? IFD_SZ_LONG : IFD_SZ_WORD;
            dec_nxt.src_kind = IFD_OPK_PCDISP;
            dec_nxt.dst_kind = IFD_OPK_REG;
            dec_nxt.dst_reg = w.fn;
            dec_nxt.disp = scale_f(d8z, dec_nxt.size);
         end
         4'ha, 4'hb: begin
            dec_nxt.fmt = IFD_FMT_D12;
            dec_nxt.src_kind = IFD_OPK_PCREL;
            dec_nxt.disp = scale_f(d12s, IFD_BR_SHIFT);
         end
         4'hc: begin
            dec_nxt.size = ifdec_size_t'(w.fn[1:0]);
            if (w.fn == 4'h3) begin
               dec_nxt.fmt = IFD_FMT_I;
               dec_nxt.src_kind = IFD_OPK_IMM;
               dec_nxt.imm = scale_f(d8z, IFD_TRAP_SHIFT);
            end else if (w.fn[3]) begin
               dec_nxt.fmt = IFD_FMT_I;
               dec_nxt.size = IFD_SZ_BYTE;
               dec_nxt.src_kind = IFD_OPK_IMM;
               dec_nxt.dst_kind = w.fn[2] ? IFD_OPK_GBRIDX : IFD_OPK_R0;
               dec_nxt.imm = d8z;
            end else if (w.fn == 4'h7) begin
               dec_nxt.fmt = IFD_FMT_D;
               dec_nxt.size = IFD_SZ_LONG;
               dec_nxt.src_kind = IFD_OPK_PCDISP;
               dec_nxt.dst_kind = IFD_OPK_R0;
               dec_nxt.disp = scale_f(d8z, IFD_SZ_LONG);
            end else begin
               dec_nxt.fmt = IFD_FMT_D;
               dec_nxt.src_kind = w.fn[2] ? IFD_OPK_GBRDISP : IFD_OPK_R0;
               dec_nxt.dst_kind = w.fn[2] ? IFD_OPK_R0 : IFD_OPK_GBRDISP;
               dec_nxt.disp = scale_f(d8z, w.fn[1:0]);
            end
         end
         default: dec_nxt.fmt = IFD_FMT_NOP;
      endcase
      // Effective address for PC forms; the datapath adds register bases itself
      if (dec_nxt.src_kind == IFD_OPK_PCDISP) begin
         if (dec_nxt.size == IFD_SZ_LONG) begin
            pcb = pc_in & IFD_PC_LONG_MASK;
         end
         dec_nxt.addr = pcb + dec_nxt.disp;
      end else if (dec_nxt.src_kind == IFD_OPK_PCREL) begin
         dec_nxt.addr = pc_in + dec_nxt.disp;
      end
      dec_nxt.valid = 1'b1;
      if (!instr_valid_in) begin
         dec_nxt = IFD_DEC_RST;
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         dec_r <= IFD_DEC_RST;
      end else begin
         dec_r <= dec_nxt;
      end
   end

   assign dec_out = dec_r;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   AST_ZERO_FMT:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in == 16'h0009 |=> dec_r.fmt == IFD_FMT_ZERO
      && dec_r.src_kind == IFD_OPK_NONE && dec_r.dst_kind == IFD_OPK_NONE)
      else $error("zero format carries an operand");
   AST_M_SRC:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in.op == 4'h4 && instr_in.fd == 4'hb
      |=> dec_r.fmt == IFD_FMT_M && dec_r.src_reg == $past(instr_in.fn))
      else $error("source-only register taken from wrong bits");
   AST_NM_SPLIT:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in.op == 4'h3 |=> dec_r.dst_reg == $past(instr_in.fn)
      && dec_r.src_reg == $past(instr_in.fm))
      else $error("two-register split wrong");
   AST_MAC:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in.op == 4'h4 && instr_in.fd == 4'hf
      |=> dec_r.src_kind == IFD_OPK_POSTINC && dec_r.dst_kind == IFD_OPK_MAC)
      else $error("multiply-accumulate operands wrong");
   AST_MD:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in.op == 4'h8 && instr_in.fn == 4'h4
      |=> dec_r.src_reg == $past(instr_in.fm) && dec_r.disp[3:0] == $past(instr_in.fd)
      && dec_r.dst_kind == IFD_OPK_R0)
      else $error("source displacement form wrong");
   AST_NMD_LONG:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in.op == 4'h1
      |=> dec_r.disp == {26'h0, $past(instr_in.fd), 2'h0})
      else $error("three-field displacement not scaled by four");
   AST_BRA:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in.op == 4'ha |=> dec_r.addr == $past(pc_in)
      + {{19{$past(instr_in.fn[3])}}, $past(instr_in[11:0]), 1'b0})
      else $error("long branch target wrong");
   AST_NI:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in.op == 4'h7 |=> dec_r.dst_reg == $past(instr_in.fn)
      && dec_r.imm[7:0] == $past(instr_in[7:0]) && dec_r.imm[31] == $past(instr_in.fm[3]))
      else $error("register immediate wrong");
   AST_PC_LONG:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in.op == 4'hd
      |=> dec_r.addr == ($past(pc_in) & IFD_PC_LONG_MASK) + {22'h0,
      $past(instr_in[7:0]), 2'h0})
      else $error("long PC-relative address wrong");
   AST_TRAP:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      instr_valid_in && instr_in.op == 4'hc && instr_in.fn == 4'h3
      |=> dec_r.imm == {22'h0, $past(instr_in[7:0]), 2'h0})
      else $error("trap immediate not quadrupled");
   AST_IDLE:
   assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
      !instr_valid_in |=> dec_r == IFD_DEC_RST)
      else $error("idle slot not cleared");

endmodule : ifdec_decoder

// File: hw/ifdec_pkg.sv
package ifdec_pkg;

   localparam int IFD_AW = 32;

   // Instruction word split into its four nibbles, bit 15 down to bit 0
   typedef struct packed {
      logic [3:0] op;
      logic [3:0] fn;
      logic [3:0] fm;
      logic [3:0] fd;
   } ifdec_word_t;

   // Format families, one-hot; all zero marks an empty slot or a valid word that decodes to no format
   typedef enum logic [11:0] {
      IFD_FMT_NOP  = 12'h000,
      IFD_FMT_ZERO = 12'h001,
      IFD_FMT_N    = 12'h002,
      IFD_FMT_M    = 12'h004,
      IFD_FMT_NM   = 12'h008,
      IFD_FMT_MD   = 12'h010,
      IFD_FMT_ND4  = 12'h020,
      IFD_FMT_NMD  = 12'h040,
      IFD_FMT_D    = 12'h080,
      IFD_FMT_D12  = 12'h100,
      IFD_FMT_ND8  = 12'h200,
      IFD_FMT_I    = 12'h400,
      IFD_FMT_NI   = 12'h800
   } ifdec_fmt_t;

   // Operand kinds
   typedef enum logic [3:0] {
      IFD_OPK_NONE    = 4'h0,
      IFD_OPK_REG     = 4'h1,
      IFD_OPK_CTRL    = 4'h2,
      IFD_OPK_IND     = 4'h3,
      IFD_OPK_POSTINC = 4'h4,
      IFD_OPK_PREDEC  = 4'h5,
      IFD_OPK_IDXR0   = 4'h6,
      IFD_OPK_DISP    = 4'h7,
      IFD_OPK_GBRDISP = 4'h8,
      IFD_OPK_GBRIDX  = 4'h9,
      IFD_OPK_PCDISP  = 4'ha,
      IFD_OPK_PCREL   = 4'hb,
      IFD_OPK_IMM     = 4'hc,
      IFD_OPK_MAC     = 4'hd,
      IFD_OPK_R0      = 4'he
   } ifdec_opk_t;

   // Operand size; the code doubles as the displacement shift
   typedef enum logic [1:0] {
      IFD_SZ_BYTE = 2'h0,
      IFD_SZ_WORD = 2'h1,
      IFD_SZ_LONG = 2'h2
   } ifdec_size_t;

   typedef struct packed {
      logic valid;
      ifdec_fmt_t fmt;
      ifdec_opk_t src_kind;
      ifdec_opk_t dst_kind;
      logic [3:0] src_reg;
      logic [3:0] dst_reg;
      ifdec_size_t size;
      logic [IFD_AW-1:0] disp;
      logic [IFD_AW-1:0] imm;
      logic [IFD_AW-1:0] addr;
   } ifdec_out_t;

   localparam ifdec_out_t IFD_DEC_RST = '0;
   localparam logic [IFD_AW-1:0] IFD_PC_LONG_MASK = 32'hffff_fffc;
   localparam logic [1:0] IFD_TRAP_SHIFT = 2'h2;
   localparam logic [1:0] IFD_BR_SHIFT = 2'h1;

endpackage : ifdec_pkg

// File: verif/ifdec_fetch_model.sv
`timescale 1ns/1ps

module ifdec_fetch_model import ifdec_pkg::*; (
   // Clock
   input wire logic clk_sys_in,
   // Fetch side toward the decoder
   output logic instr_valid_out,
   output ifdec_word_t instr_out,
   output logic [IFD_AW-1:0] pc_out
);

   initial begin
      instr_valid_out = 1'b0;
      instr_out = 16'h0000;
      pc_out = 32'h0000_0000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One word per call, held until the next send or idle call drives the fetch side again
   task automatic send(input logic [15:0] word, input logic [IFD_AW-1:0] pc);
      @(posedge clk_sys_in);
      instr_valid_out <= 1'b1;
      instr_out <= word;
      pc_out <= pc;
   endtask : send

   // Empty slot: the stale word is inverted so a decoder that ignores valid is caught
   task automatic idle();
      @(posedge clk_sys_in);
      instr_valid_out <= 1'b0;
      instr_out <= ~instr_out;
      pc_out <= ~pc_out;
   endtask : idle

endmodule : ifdec_fetch_model

// File: verif/test_instruction_format_field_decoder.sv
`timescale 1ns/1ps

module test_instruction_format_field_decoder import ifdec_pkg::*;;

   localparam logic [31:0] DC = 32'hxxxx_xxxx;
   localparam logic [31:0] Z = 32'h0;

   logic clk_sys_in;
   logic rst_n_in;
   logic instr_valid;
   ifdec_word_t instr;
   logic [IFD_AW-1:0] pc;
   ifdec_out_t dec;
   int err_count = 0;
   int samples_checked = 0;

   ifdec_fetch_model ifdec_fetch_model_i (
      .clk_sys_in(clk_sys_in),
      .instr_valid_out(instr_valid),
      .instr_out(instr),
      .pc_out(pc)
   );

   ifdec_decoder ifdec_decoder_i (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .instr_valid_in(instr_valid),
      .instr_in(instr),
      .pc_in(pc),
      .dec_out(dec)
   );

   initial begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // All-x expected value means the field is free for this word
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      if (exp !== DC) begin
         samples_checked++;
         if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
         end
      end
   endtask : chk

   task automatic chk_empty(input string name);
      samples_checked++;
      if (dec !== IFD_DEC_RST) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", name, IFD_DEC_RST, dec);
      end
   endtask : chk_empty

   // Answer lands on the edge that takes the word, so look just after that edge
   task automatic decode(input logic [15:0] w, input logic [31:0] p, fmt, sk, dk, sr, dr,
                         disp, imm, addr);
      ifdec_fetch_model_i.send(w, p);
      ifdec_fetch_model_i.idle();
      #1;
      chk("valid", 32'h1, 32'(dec.valid));
      chk("fmt", fmt, 32'(dec.fmt));
      chk("src_kind", sk, 32'(dec.src_kind));
      chk("dst_kind", dk, 32'(dec.dst_kind));
      chk("src_reg", sr, 32'(dec.src_reg));
      chk("dst_reg", dr, 32'(dec.dst_reg));
      chk("disp", disp, dec.disp);
      chk("imm", imm, dec.imm);
      chk("addr", addr, dec.addr);
   endtask : decode

   ////////////////////////////////////////////////////////////////////////////////
   task automatic sc_register_forms();
      decode(16'h0009, Z, IFD_FMT_ZERO, IFD_OPK_NONE, IFD_OPK_NONE, Z, Z, DC, DC, Z);
      decode(16'h0502, Z, IFD_FMT_N, IFD_OPK_CTRL, IFD_OPK_REG, Z, 32'h5, DC, DC, Z);
      decode(16'h0a23, Z, IFD_FMT_M, IFD_OPK_REG, IFD_OPK_NONE, 32'ha, Z, DC, DC, Z);
      decode(16'h4c07, Z, IFD_FMT_M, IFD_OPK_POSTINC, IFD_OPK_CTRL, 32'hc, Z, DC, DC, Z);
      decode(16'h4a0e, Z, IFD_FMT_M, IFD_OPK_REG, IFD_OPK_CTRL, 32'ha, Z, DC, DC, Z);
      decode(16'h3a5c, Z, IFD_FMT_NM, IFD_OPK_REG, IFD_OPK_REG, 32'h5, 32'ha, DC, DC, Z);
      decode(16'h2136, Z, IFD_FMT_NM, IFD_OPK_REG, IFD_OPK_PREDEC, 32'h3, 32'h1, DC, DC, Z);
      decode(16'h6346, Z, IFD_FMT_NM, IFD_OPK_POSTINC, IFD_OPK_REG, 32'h4, 32'h3, DC, DC, Z);
      decode(16'h0b66, Z, IFD_FMT_NM, IFD_OPK_REG, IFD_OPK_IDXR0, 32'h6, 32'hb, DC, DC, Z);
      decode(16'h0b6e, Z, IFD_FMT_NM, IFD_OPK_IDXR0, IFD_OPK_REG, 32'h6, 32'hb, DC, DC, Z);
      decode(16'h4e8f, Z, IFD_FMT_NM, IFD_OPK_POSTINC, IFD_OPK_MAC, 32'h8, 32'he, DC, DC, Z);
      decode(16'h0e8f, Z, IFD_FMT_NM, IFD_OPK_POSTINC, IFD_OPK_MAC, 32'h8, 32'he, DC, DC, Z);
      decode(16'hf123, Z, IFD_FMT_NOP, IFD_OPK_NONE, IFD_OPK_NONE, Z, Z, DC, DC, Z);
      decode(16'h8200, Z, IFD_FMT_NOP, IFD_OPK_NONE, IFD_OPK_NONE, Z, Z, Z, Z, Z);
      decode(16'h0829, Z, IFD_FMT_N, IFD_OPK_NONE, IFD_OPK_REG, Z, 32'h8, DC, DC, Z);
      decode(16'h4523, Z, IFD_FMT_N, IFD_OPK_CTRL, IFD_OPK_PREDEC, Z, 32'h5, DC, DC, Z);
      decode(16'h4100, Z, IFD_FMT_N, IFD_OPK_NONE, IFD_OPK_REG, Z, 32'h1, DC, DC, Z);
      decode(16'h2710, Z, IFD_FMT_NM, IFD_OPK_REG, IFD_OPK_IND, 32'h1, 32'h7, DC, DC, Z);
      decode(16'h6710, Z, IFD_FMT_NM, IFD_OPK_IND, IFD_OPK_REG, 32'h1, 32'h7, DC, DC, Z);
   endtask : sc_register_forms

   task automatic sc_displacements();
      decode(16'h857b, Z, IFD_FMT_MD, IFD_OPK_DISP, IFD_OPK_R0, 32'h7, Z, 32'h16, DC, Z);
      chk("size", 32'(IFD_SZ_WORD), 32'(dec.size));
      decode(16'h843f, Z, IFD_FMT_MD, IFD_OPK_DISP, IFD_OPK_R0, 32'h3, Z, 32'hf, DC, Z);
      decode(16'h81af, Z, IFD_FMT_ND4, IFD_OPK_R0, IFD_OPK_DISP, Z, 32'ha, 32'h1e, DC, Z);
      decode(16'h1a5f, Z, IFD_FMT_NMD, IFD_OPK_REG, IFD_OPK_DISP, 32'h5, 32'ha, 32'h3c, DC,
             Z);
      decode(16'h5a5f, Z, IFD_FMT_NMD, IFD_OPK_DISP, IFD_OPK_REG, 32'h5, 32'ha, 32'h3c, DC,
             Z);
      decode(16'hc6ff, Z, IFD_FMT_D, IFD_OPK_GBRDISP, IFD_OPK_R0, Z, Z, 32'h3fc, DC, Z);
      decode(16'hc2ff, Z, IFD_FMT_D, IFD_OPK_R0, IFD_OPK_GBRDISP, Z, Z, 32'h3fc, DC, Z);
      decode(16'hc4ff, Z, IFD_FMT_D, IFD_OPK_GBRDISP, IFD_OPK_R0, Z, Z, 32'hff, DC, Z);
      decode(16'hc781, 32'h1002, IFD_FMT_D, IFD_OPK_PCDISP, IFD_OPK_R0, Z, Z, 32'h204, DC,
             32'h1204);
      decode(16'h8b80, 32'h2000, IFD_FMT_D, IFD_OPK_PCREL, IFD_OPK_NONE, Z, Z, 32'hffff_ff00, DC,
             32'h1f00);
      decode(16'h8f7f, 32'h2000, IFD_FMT_D, IFD_OPK_PCREL, DC, Z, Z, 32'hfe, DC,
             32'h20fe);
      decode(16'ha801, 32'h4000, IFD_FMT_D12, IFD_OPK_PCREL, IFD_OPK_NONE, Z, Z, 32'hffff_f002, DC,
             32'h3002);
      decode(16'hb7ff, 32'h4000, IFD_FMT_D12, IFD_OPK_PCREL, DC, Z, Z, 32'hffe, DC,
             32'h4ffe);
      decode(16'hd3ff, 32'h3006, IFD_FMT_ND8, IFD_OPK_PCDISP, IFD_OPK_REG, Z, 32'h3, 32'h3fc, DC,
             32'h3400);
      chk("size", 32'(IFD_SZ_LONG), 32'(dec.size));
      decode(16'h9380, 32'h3006, IFD_FMT_ND8, IFD_OPK_PCDISP, IFD_OPK_REG, Z, 32'h3, 32'h100, DC,
             32'h3106);
      chk("size", 32'(IFD_SZ_WORD), 32'(dec.size));
   endtask : sc_displacements

   // Low byte 80 in four words, extended per opcode, plus a scaled trap word and a positive byte
   task automatic sc_immediates();
      decode(16'hc3ff, Z, IFD_FMT_I, IFD_OPK_IMM, IFD_OPK_NONE, Z, Z, DC, 32'h3fc, Z);
      decode(16'hc880, Z, IFD_FMT_I, IFD_OPK_IMM, IFD_OPK_R0, Z, Z, DC, 32'h80, Z);
      decode(16'h8880, Z, IFD_FMT_I, IFD_OPK_IMM, IFD_OPK_R0, Z, Z, DC, 32'hffff_ff80, Z);
      decode(16'hcc80, Z, IFD_FMT_I, IFD_OPK_IMM, IFD_OPK_GBRIDX, Z, Z, DC, 32'h80, Z);
      decode(16'h7f80, Z, IFD_FMT_NI, IFD_OPK_IMM, IFD_OPK_REG, Z, 32'hf, DC, 32'hffff_ff80,
             Z);
      decode(16'he27f, Z, IFD_FMT_NI, IFD_OPK_IMM, IFD_OPK_REG, Z, 32'h2, DC, 32'h7f, Z);
   endtask : sc_immediates

   // Back-to-back words, then an empty slot that must clear the output
   task automatic sc_stream();
      ifdec_fetch_model_i.send(16'h7f80, Z);
      ifdec_fetch_model_i.send(16'he27f, Z);
      #1;
      chk("stream first imm", 32'hffff_ff80, dec.imm);
      ifdec_fetch_model_i.idle();
      #1;
      chk("stream second dst_reg", 32'h2, 32'(dec.dst_reg));
      ifdec_fetch_model_i.idle();
      #1;
      chk_empty("stream empty slot");
   endtask : sc_stream

   // Reset lands on the edge that takes a word; the output must still clear
   task automatic sc_mid_reset();
      ifdec_fetch_model_i.send(16'h3a5c, Z);
      @(posedge clk_sys_in);
      rst_n_in <= 1'b0;
      #1;
      chk_empty("async reset");
      ifdec_fetch_model_i.idle();
      @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      decode(16'h3a5c, Z, IFD_FMT_NM, IFD_OPK_REG, IFD_OPK_REG, 32'h5, 32'ha, DC, DC, Z);
   endtask : sc_mid_reset

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : finish_test

   // Guard against a hang; the whole sequence needs far fewer cycles
   initial begin
      repeat (2000) @(posedge clk_sys_in);
      err_count++;
      $display("mismatch watchdog expected done seen running");
      finish_test();
   end

   initial begin
      rst_n_in = 1'b0;
      repeat (4) @(posedge clk_sys_in);
      #1;
      chk_empty("reset value");
      @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      sc_register_forms();
      sc_displacements();
      sc_immediates();
      sc_stream();
      sc_mid_reset();
      finish_test();
   end

endmodule : test_instruction_format_field_decoder
